// file: core/sactx_pkg.sv
// Package for the transmit configuration word control block.
// Assumes a 32-bit APB slave at byte offsets, one clock domain.
package sactx_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] TRANSMIT_CONFIG_WORD_CONTROL_CTRL_OFFSET = 12'h178;
    localparam logic [11:0] MODE_CTRL_OFFSET = 12'h17C;
    localparam logic [11:0] STATUS_OFFSET = 12'h184;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HW_AUTONEG_ENABLE_BIT = 31;
    localparam int SEND_CONFIG_SETS_BIT = 30;
    localparam int RSVD_HI_MSB = 29;
    localparam int RSVD_HI_LSB = 16;
    localparam int NEXT_PAGE_BIT = 15;
    localparam int PAUSE_MSB = 8;
    localparam int PAUSE_LSB = 7;
    localparam int HALF_DUPLEX_BIT = 6;
    localparam int FULL_DUPLEX_BIT = 5;
    // Writable advertised bits: 15, 13:12, 8:5; reserved 14, 11:9, 4:0
    localparam logic [15:0] WORD_WRITE_MASK = 16'hB1E0;
    // Bits loaded from nonvolatile memory: 8, 7, 5
    localparam logic [15:0] WORD_PRELOAD_MASK = 16'h01A0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic MODE_SERDES_RESET = 1'b0;
    // ------------------------------------------------------------
    // Transmit selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TX_DATA_IDLE, TX_CONFIG_SETS, TX_OFF} sactx_tx_sel_type;
endpackage : sactx_pkg

// file: core/sactx_ctl_if.sv
// Interface carrying the control view from register file to negotiation sequencer.
// Assumes both ends share pclk.
`timescale 1ns/1ps
interface sactx_ctl_if;
    logic hw_enable;
    logic restart;
    logic send_config_sets;
    logic serdes_mode;
    logic [15:0] config_word;
    logic busy;
    modport regs (output hw_enable, output restart, output send_config_sets, output serdes_mode,
        output config_word, input busy);
    modport seq (input hw_enable, input restart, input send_config_sets, input serdes_mode,
        input config_word, output busy);
endinterface : sactx_ctl_if

// file: core/sactx_sync_edge.sv
// Rising-edge detector for the receiver synchronised level.
// Assumes rx level is already synchronous to pclk.
`timescale 1ns/1ps
module sactx_sync_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic rise
);
    typedef struct packed
    {
        logic prev;
        logic rise;
    } sactx_edge_type;
    sactx_edge_type state_reg;
    sactx_edge_type state_next;
    // Loss-to-sync transition
    always_comb
    begin
        state_next.prev = level;
        state_next.rise = level & ~state_reg.prev;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign rise = state_reg.rise;
endmodule : sactx_sync_edge

// file: core/sactx_seq.sv
// Negotiation transmit sequencer: picks /C/ sets, data or off and the word sent.
// Assumes a PCS encoder consumes tx_sel and tx_word and does 8b/10b itself.
`timescale 1ns/1ps
module sactx_seq (
    input wire logic pclk,
    input wire logic presetn,
    sactx_ctl_if.seq ctl,
    input wire logic resync,
    output logic [1:0] tx_sel,
    output logic [15:0] tx_word,
    output logic an_restart
);
    typedef struct packed
    {
        logic [1:0] sel;
        logic [15:0] word;
        logic restart;
    } sactx_seq_type;
    sactx_seq_type state_reg;
    sactx_seq_type state_next;
    // Off outside SerDes mode; else hardware mode sends the word in /C/ sets; software mode follows send bit
    always_comb
    begin
        state_next = state_reg;
        state_next.word = ctl.config_word;
        state_next.restart = ctl.hw_enable & (ctl.restart | resync);
        if (!ctl.serdes_mode)
        begin
            state_next.sel = sactx_pkg::TX_OFF;
        end
        else if (ctl.hw_enable)
        begin
            state_next.sel = sactx_pkg::TX_CONFIG_SETS;
        end
        else if (ctl.send_config_sets)
        begin
            state_next.sel = sactx_pkg::TX_CONFIG_SETS;
        end
        else
        begin
            state_next.sel = sactx_pkg::TX_DATA_IDLE;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '{sel: sactx_pkg::TX_OFF, word: sactx_pkg::WORD_RESET, restart: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign tx_sel = state_reg.sel;
    assign tx_word = state_reg.word;
    assign an_restart = state_reg.restart;
    assign ctl.busy = state_reg.restart;
endmodule : sactx_seq

// file: core/sactx_top.sv
// Top of the transmit configuration word control block with its APB slave.
// Assumes APB master on pclk; nvm preload values are stable while nvm_load pulses.
`timescale 1ns/1ps
module sactx_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nvm_load,
    input wire logic [15:0] nvm_word,
    input wire logic nvm_autoneg_enable,
    input wire logic rx_synchronized,
    output logic [1:0] tx_sel,
    output logic [15:0] tx_word,
    output logic an_restart
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic hw_enable;
        logic send_config_sets;
        logic [15:0] word;
        logic serdes_mode;
        logic restart;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } sactx_top_type;
    sactx_top_type state_reg;
    sactx_top_type state_next;
    sactx_ctl_if ctl ();
    logic resync;
    logic setup;
    logic wr;
    logic rd;
    logic [31:0] ctrl_view;
    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // No wait state: ready rises in the first access cycle, so read data comes from a flop
    assign setup = psel & ~penable;
    assign wr = psel & penable & state_reg.ready & pwrite;
    assign rd = setup & ~pwrite;
    // Reserved 29:16 forced to zero on read
    assign ctrl_view = {state_reg.hw_enable, state_reg.send_config_sets, 14'h0000, state_reg.word};
    // Register update and answer
    always_comb
    begin
        state_next = state_reg;
        state_next.restart = 1'b0;
        state_next.ready = setup;
        // Error flop only lives for the access cycle so pslverr can come straight from it
        state_next.err = setup & ~(paddr == sactx_pkg::TRANSMIT_CONFIG_WORD_CONTROL_CTRL_OFFSET || paddr == sactx_pkg::MODE_CTRL_OFFSET
            || paddr == sactx_pkg::STATUS_OFFSET);
        if (rd)
        begin
            case (paddr)
                sactx_pkg::TRANSMIT_CONFIG_WORD_CONTROL_CTRL_OFFSET: state_next.rdata = ctrl_view;
                sactx_pkg::MODE_CTRL_OFFSET: state_next.rdata = {31'h00000000, state_reg.serdes_mode};
                sactx_pkg::STATUS_OFFSET: state_next.rdata = {29'h00000000, tx_sel, an_restart};
                default: state_next.rdata = 32'h00000000;
            endcase
        end
        if (wr && !state_reg.err)
        begin
            case (paddr)
                sactx_pkg::TRANSMIT_CONFIG_WORD_CONTROL_CTRL_OFFSET:
                begin
                    state_next.hw_enable = pwdata[sactx_pkg::HW_AUTONEG_ENABLE_BIT];
                    state_next.send_config_sets = pwdata[sactx_pkg::SEND_CONFIG_SETS_BIT];
                    // Reserved word bits dropped so the link never sends them
                    state_next.word = pwdata[15:0] & sactx_pkg::WORD_WRITE_MASK;
                    state_next.restart = pwdata[sactx_pkg::HW_AUTONEG_ENABLE_BIT];
                end
                sactx_pkg::MODE_CTRL_OFFSET: state_next.serdes_mode = pwdata[0];
                default: state_next.serdes_mode = state_reg.serdes_mode;
            endcase
        end
        // Preload from nonvolatile memory after power-up or chip reset
        if (nvm_load)
        begin
            state_next.word = (state_reg.word & ~sactx_pkg::WORD_PRELOAD_MASK)
                | (nvm_word & sactx_pkg::WORD_PRELOAD_MASK);
            state_next.hw_enable = nvm_autoneg_enable;
        end
    end
    // Constant reset; nvm values are caught by the clocked load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '{hw_enable: 1'b0, send_config_sets: 1'b0, word: sactx_pkg::WORD_RESET,
                serdes_mode: sactx_pkg::MODE_SERDES_RESET, restart: 1'b0, ready: 1'b0, err: 1'b0,
                rdata: 32'h00000000};
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    assign ctl.hw_enable = state_reg.hw_enable;
    assign ctl.restart = state_reg.restart;
    assign ctl.send_config_sets = state_reg.send_config_sets;
    assign ctl.serdes_mode = state_reg.serdes_mode;
    assign ctl.config_word = state_reg.word;
    sactx_sync_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(rx_synchronized),
        .rise(resync)
    );
    sactx_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(ctl),
        .resync(resync),
        .tx_sel(tx_sel),
        .tx_word(tx_word),
        .an_restart(an_restart)
    );
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
endmodule : sactx_top

// file: verification/sactx_monitor.sv
// Checker for the transmit configuration word control block.
// Assumes it is bound onto sactx_top and sees only its ports.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module sactx_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nvm_load,
    input wire logic nvm_autoneg_enable,
    input wire logic rx_synchronized,
    input wire logic [1:0] tx_sel,
    input wire logic [15:0] tx_word,
    input wire logic an_restart
);
    logic en_reg;
    logic ack;
    logic rd;
    // Completed transfers to the control register; a write only counts without an error
    assign ack = psel && penable && pready && pwrite && paddr == sactx_pkg::TRANSMIT_CONFIG_WORD_CONTROL_CTRL_OFFSET && !pslverr;
    assign rd = psel && penable && pready && !pwrite && paddr == sactx_pkg::TRANSMIT_CONFIG_WORD_CONTROL_CTRL_OFFSET;
    // Shadow of the enable bit; preload wins as in the design
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_reg <= 1'b0;
        else if (nvm_load)
            en_reg <= nvm_autoneg_enable;
        else if (ack)
            en_reg <= pwdata[31];
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Local copy keeps the word even if the master changes pwdata
    property p_word;
        logic [15:0] w;
        (ack, w = pwdata[15:0]) |-> ##2 tx_word == (w & sactx_pkg::WORD_WRITE_MASK);
    endproperty
    a_restart_on_write: assert property (ack && pwdata[31] |-> ##2 an_restart)
        else $error("no restart after enable write");
    a_restart_pulse: assert property (an_restart |=> !an_restart)
        else $error("restart pulse longer than one cycle");
    a_resync_restart: assert property ($rose(rx_synchronized) && en_reg |-> ##[1:3] an_restart)
        else $error("no restart on regained sync");
    a_word_follows: assert property (p_word)
        else $error("sent word differs from written word");
    a_sel_legal: assert property (tx_sel != 2'h3)
        else $error("illegal transmit selection");
    a_rsvd_high: assert property (rd |-> prdata[29:16] == 14'h0000)
        else $error("reserved high bits read nonzero");
    a_rsvd_word: assert property (rd |-> (prdata[15:0] & ~sactx_pkg::WORD_WRITE_MASK) == 16'h0000)
        else $error("reserved word bits read nonzero");
    a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access pulse");
    a_unmapped_err: assert property (psel && penable && pready && !(paddr inside {12'h178, 12'h17C, 12'h184})
        |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    c_restart: cover property (an_restart);
    c_sets: cover property (tx_sel == 2'h1);
    c_refused: cover property (pslverr);
endmodule : sactx_monitor

bind sactx_top sactx_monitor sactx_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_load(nvm_load), .nvm_autoneg_enable(nvm_autoneg_enable), .rx_synchronized(rx_synchronized),
    .tx_sel(tx_sel), .tx_word(tx_word), .an_restart(an_restart));

// file: verification/sactx_link_partner.sv
// Behavioural remote link partner on the serial side.
// Assumes the bench commands sync loss; captures the word of received /C/ sets.
`timescale 1ns/1ps
module sactx_link_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] tx_sel,
    input wire logic [15:0] tx_word,
    input wire logic lose_sync,
    output logic rx_synchronized,
    output logic [15:0] seen_word
);
    // Sync follows the command a cycle late, like a real lock detector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_synchronized <= 1'b0;
            seen_word <= 16'h0000;
        end
        else
        begin
            rx_synchronized <= !lose_sync;
            if (tx_sel == 2'h1)
                seen_word <= tx_word;
        end
    end
endmodule : sactx_link_partner

// file: verification/serdes_autoneg_tx_config_tb.sv
// Self-checking bench for the transmit configuration word control block.
// Assumes sactx_top, the bound checker and the link partner model.
`timescale 1ns/1ps
module serdes_autoneg_tx_config_tb;
    typedef struct {logic [31:0] mode; logic [31:0] wdata; logic [1:0] sel; logic [31:0] rd;} sactx_row_type;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, an_restart;
    logic nvm_load = 0, nvm_autoneg_enable = 0, rx_synchronized, lose_sync = 0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] nvm_word = 16'h0000, tx_word, seen_word;
    logic [1:0] tx_sel;
    int err_total = 0, n_compared = 0, n_rst = 0, c0;
    sactx_row_type rows[5] = '{'{1, 32'h4000_01A0, 2'h1, 32'h4000_01A0}, '{1, 32'h0000_8060, 2'h0, 32'h0000_8060},
        '{1, 32'h8000_B1E0, 2'h1, 32'h8000_B1E0}, '{1, 32'h3FFF_FFFF, 2'h0, 32'h0000_B1E0}, '{0, 0, 2'h2, 0}};
    sactx_top sactx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_load(nvm_load),
        .nvm_word(nvm_word), .nvm_autoneg_enable(nvm_autoneg_enable), .rx_synchronized(rx_synchronized),
        .tx_sel(tx_sel), .tx_word(tx_word), .an_restart(an_restart));
    sactx_link_partner sactx_link_partner_inst (.pclk(pclk), .presetn(presetn), .tx_sel(tx_sel),
        .tx_word(tx_word), .lose_sync(lose_sync), .rx_synchronized(rx_synchronized), .seen_word(seen_word));
    // 50 MHz clock and a count of restart pulses
    always #10 pclk = ~pclk;
    always @(posedge pclk)
        if (an_restart === 1'b1) n_rst++;
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 50)
        begin
            err_total++;
            final_report();
        end
    endtask : apb
    task settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h178, 0);
        chk("reset word", 0, r);
        chk("reset sel", 2, tx_sel);
        foreach (rows[k])
        begin
            apb(1, 12'h17C, rows[k].mode);
            apb(1, 12'h178, rows[k].wdata);
            settle(4);
            chk("sel", rows[k].sel, tx_sel);
            if (rows[k].sel == 2'h1) chk("sent word", rows[k].rd[15:0], seen_word);
            // Read back only while sync is steady; other reads are not relied on
            apb(0, 12'h178, 0);
            chk("read back", rows[k].rd, r);
        end
        // Repeated enable writes, then sync loss with enable on and off
        apb(1, 12'h17C, 1);
        c0 = n_rst;
        apb(1, 12'h178, 32'h8000_0000);
        apb(1, 12'h178, 32'h8000_0000);
        settle(4);
        chk("restarts", c0 + 2, n_rst);
        for (int en = 1; en >= 0; en--)
        begin
            apb(1, 12'h178, {en[0], 31'h0});
            lose_sync <= 1;
            settle(4);
            c0 = n_rst;
            lose_sync <= 0;
            settle(6);
            chk("resync restarts", c0 + en, n_rst);
        end
        // Preload sets only word bits 8,7,5 and the enable
        nvm_word <= 16'hFFFF;
        nvm_autoneg_enable <= 1;
        nvm_load <= 1;
        @(posedge pclk);
        nvm_load <= 0;
        apb(0, 12'h178, 0);
        chk("preload", 32'h8000_01A0, r);
        apb(0, 12'h100, 0);
        chk("unmapped", 32'h0000_0000, r);
        chk("unmapped err", 1, e);
        final_report();
    end
endmodule : serdes_autoneg_tx_config_tb
